// ==== timer8_pkg.sv ====
// Shared constants and types for the 8-bit compare and waveform timer
package timer8_pkg;

	// Register offsets on the plain register port
	localparam int          ADDR_W    = 3;
	localparam logic [2:0]  CTRL_OFS  = 3'h0;
	localparam logic [2:0]  COUNT_OFS = 3'h1;
	localparam logic [2:0]  CMP_OFS   = 3'h2;
	localparam logic [2:0]  FLAG_OFS  = 3'h3;
	localparam logic [2:0]  PIN_OFS   = 3'h4;

	// Control register fields
	localparam int          WAVE_LSB  = 0;
	localparam int          ACT_LSB   = 2;
	localparam int          CS_LSB    = 4;
	localparam int          FORCE_BIT = 7;

	// Flag register fields
	localparam int          OVF_BIT   = 0;
	localparam int          CMPF_BIT  = 1;

	// Pin register fields
	localparam int          STATE_BIT = 0;
	localparam int          DIR_BIT   = 1;
	localparam int          PORT_BIT  = 2;

	// Count values and reset values
	localparam logic [7:0]  COUNT_MAX    = 8'hff;
	localparam logic [7:0]  COUNT_BOTTOM = 8'h00;
	localparam logic [7:0]  RESET_BYTE   = 8'h00;
	localparam logic [7:0]  READ_ZERO    = 8'h00;

	// Prescaler: divider width and tap masks
	localparam int          PRE_W    = 10;
	localparam logic [9:0]  PRE_ZERO = 10'h000;
	localparam logic [9:0]  PRE_ONE  = 10'h001;
	localparam logic [9:0]  MASK_8   = 10'h007;
	localparam logic [9:0]  MASK_64  = 10'h03f;
	localparam logic [9:0]  MASK_256 = 10'h0ff;
	localparam logic [9:0]  MASK_1K  = 10'h3ff;

	typedef enum logic [1:0] {
		wave_normal,
		wave_phase,
		wave_ctc,
		wave_fast
	} wave_e;

	typedef enum logic [1:0] {
		act_none,
		act_toggle,
		act_clear,
		act_set
	} act_e;

	typedef enum logic [2:0] {
		cs_stop,
		cs_div1,
		cs_div8,
		cs_div64,
		cs_div256,
		cs_div1024,
		cs_rsv6,
		cs_rsv7
	} cs_e;

endpackage : timer8_pkg

// ==== tick_if.sv ====
// Timer clock enable link between the timer core and its prescaler
`timescale 1ns/1ns
interface tick_if;
	timer8_pkg::cs_e clk_sel;
	logic            tick;

	modport core
	(
		output clk_sel,
		input  tick
	);

	modport pre
	(
		input  clk_sel,
		output tick
	);
endinterface : tick_if

// ==== timer8_prescaler.sv ====
// Prescaler making the one-cycle timer clock enable
`timescale 1ns/1ns
module timer8_prescaler
(
	input  wire logic core_clk,
	input  wire logic resetn,
	tick_if.pre       tk
);

	typedef struct packed {
		logic [9:0] pre;
		logic       tick;
	} pre_s;

	pre_s r;
	pre_s r_nxt;

	function automatic logic tap(input logic [9:0] cnt,
	                             input logic [9:0] mask);
		tap = (cnt & mask) == mask;
	endfunction : tap

	// Divider runs free; the tap ratio selects 1, 8, 64, 256 or 1024
	always_comb
	begin
		r_nxt     = r;
		r_nxt.pre = r.pre + timer8_pkg::PRE_ONE;
		unique case (tk.clk_sel)
			timer8_pkg::cs_div1:    r_nxt.tick = 1'b1;
			timer8_pkg::cs_div8:    r_nxt.tick = tap(r.pre, timer8_pkg::MASK_8);
			timer8_pkg::cs_div64:   r_nxt.tick = tap(r.pre, timer8_pkg::MASK_64);
			timer8_pkg::cs_div256:  r_nxt.tick = tap(r.pre, timer8_pkg::MASK_256);
			timer8_pkg::cs_div1024: r_nxt.tick = tap(r.pre, timer8_pkg::MASK_1K);
			default:                r_nxt.tick = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			r.pre  <= timer8_pkg::PRE_ZERO;
			r.tick <= 1'b0;
		end
		else
		begin
			r <= r_nxt;
		end
	end

	assign tk.tick = r.tick;

endmodule : timer8_prescaler

// ==== timer8_wavegen.sv ====
// 8-bit timer with compare match, waveform output and pin override
//
// Operation
// - Reset clears compare output state to zero
// - Nonzero action select drives pin from state
// - Override ignores waveform mode
// - Software may preset state before enabling pin
// - Action zero leaves state unchanged on match
// - New action at next match; force applies now
// - Mode sets counting; action sets output only
// - Mode 0 counts up, wraps ff to 00
// - Normal mode overflow flag set at zero
// - Count writable any time in normal mode
// - Mode 2 clears after count equals compare
// - Compare below count waits for wrap
// - Compare flag set at each match
// - Action 1 toggles on every match
// - Prescale 1, 8, 64, 256, 1024
// - Mode 2 overflow set passing max to zero
// - Mode 3 counts 0 to max, 256 ticks
// - Fast PWM: 2 clear-match set-bottom, 3 reverse
// - Fast PWM overflow set at max
// - Compare 0 spike, compare max constant level
// - Fast PWM toggle gives square, buffered compare
// - Match sets flag; write-one or ack clears
// - Count write blocks match next timer tick
// - Force updates state outside PWM modes, no flag, no clear
// - PWM compare buffered to top, else immediate
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ns
module timer8_wavegen
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       ovf_ack,
	input  wire logic       cmp_ack,
	output logic            ovf_flag,
	output logic            cmp_flag,
	output logic            pin_out,
	output logic            pin_oe
);

	typedef struct packed {
		logic [7:0]           count;
		logic [7:0]           cmp_buf;
		logic [7:0]           cmp_act;
		timer8_pkg::wave_e    wave;
		timer8_pkg::act_e     act;
		timer8_pkg::cs_e      cs;
		logic                 ovf;
		logic                 cmpf;
		logic                 state;
		logic                 dir;
		logic                 port;
		logic                 block;
		logic [7:0]           rdata;
		logic                 pin_out;
		logic                 pin_oe;
	} tmr_s;

	tmr_s r;
	tmr_s r_nxt;

	tick_if tk ();

	timer8_prescaler u_pre
	(
		.core_clk (core_clk),
		.resetn   (resetn),
		.tk       (tk)
	);

	assign tk.clk_sel = r.cs;

	// New output state for one match under a given action
	function automatic logic apply_act(input timer8_pkg::act_e a,
	                                   input logic             s);
		unique case (a)
			timer8_pkg::act_none:   apply_act = s;
			timer8_pkg::act_toggle: apply_act = ~s;
			timer8_pkg::act_clear:  apply_act = 1'b0;
			timer8_pkg::act_set:    apply_act = 1'b1;
		endcase
	endfunction : apply_act

	function automatic logic is_pwm(input timer8_pkg::wave_e w);
		is_pwm = (w == timer8_pkg::wave_fast) ||
		         (w == timer8_pkg::wave_phase);
	endfunction : is_pwm

	logic              tick;
	logic              top;
	logic              match;
	timer8_pkg::wave_e wr_wave;
	timer8_pkg::act_e  wr_act;

	assign tick    = tk.tick;
	assign top     = r.count == timer8_pkg::COUNT_MAX;
	assign wr_wave = timer8_pkg::wave_e'(wdata[timer8_pkg::WAVE_LSB +: 2]);
	assign wr_act  = timer8_pkg::act_e'(wdata[timer8_pkg::ACT_LSB +: 2]);
	// Blocked for one tick after a count write
	assign match   = tick && !r.block && (r.count == r.cmp_act);

	always_comb
	begin
		r_nxt       = r;
		r_nxt.rdata = timer8_pkg::READ_ZERO;

		// Clears first so a same-cycle hardware set wins
		if (wr && addr == timer8_pkg::FLAG_OFS)
		begin
			if (wdata[timer8_pkg::OVF_BIT])
				r_nxt.ovf = 1'b0;
			if (wdata[timer8_pkg::CMPF_BIT])
				r_nxt.cmpf = 1'b0;
		end
		if (ovf_ack)
			r_nxt.ovf = 1'b0;
		if (cmp_ack)
			r_nxt.cmpf = 1'b0;

		if (tick)
		begin
			r_nxt.block = 1'b0;
			// Sequence depends on the mode field and the compare match, not on the action
			if (r.wave == timer8_pkg::wave_ctc && match)
				r_nxt.count = timer8_pkg::COUNT_BOTTOM;
			else
				r_nxt.count = r.count + 8'h01;
			if (top)
				r_nxt.ovf = 1'b1;
			if (match)
				r_nxt.cmpf = 1'b1;
			if (is_pwm(r.wave) && top)
				r_nxt.cmp_act = r.cmp_buf;

			if (r.wave == timer8_pkg::wave_fast)
			begin
				if (r.act == timer8_pkg::act_toggle)
				begin
					if (match)
						r_nxt.state = ~r.state;
				end
				else if (r.act != timer8_pkg::act_none)
				begin
					// Bottom wins over a max compare: constant level
					if (top)
						r_nxt.state = r.act == timer8_pkg::act_clear;
					else if (match)
						r_nxt.state = r.act == timer8_pkg::act_set;
				end
			end
			else if (match)
			begin
				// Action zero keeps the state
				r_nxt.state = apply_act(r.act, r.state);
			end
		end

		if (wr)
		begin
			unique case (addr)
				timer8_pkg::CTRL_OFS:
				begin
					r_nxt.wave = wr_wave;
					r_nxt.act  = wr_act;
					r_nxt.cs   = timer8_pkg::cs_e'(wdata[timer8_pkg::CS_LSB +: 3]);
					if (!is_pwm(wr_wave))
						r_nxt.cmp_act = r.cmp_buf;
					// Forced match: output only, counter and flag untouched
					if (wdata[timer8_pkg::FORCE_BIT] && !is_pwm(wr_wave))
						r_nxt.state = apply_act(wr_act, r.state);
				end
				timer8_pkg::COUNT_OFS:
				begin
					r_nxt.count = wdata;
					r_nxt.block = 1'b1;
				end
				timer8_pkg::CMP_OFS:
				begin
					r_nxt.cmp_buf = wdata;
					if (!is_pwm(r.wave))
						r_nxt.cmp_act = wdata;
				end
				timer8_pkg::PIN_OFS:
				begin
					r_nxt.state = wdata[timer8_pkg::STATE_BIT];
					r_nxt.dir   = wdata[timer8_pkg::DIR_BIT];
					r_nxt.port  = wdata[timer8_pkg::PORT_BIT];
				end
				default:
				begin
				end
			endcase
		end

		if (rd)
		begin
			unique case (addr)
				timer8_pkg::CTRL_OFS:
				begin
					r_nxt.rdata[timer8_pkg::WAVE_LSB +: 2] = r.wave;
					r_nxt.rdata[timer8_pkg::ACT_LSB +: 2]  = r.act;
					r_nxt.rdata[timer8_pkg::CS_LSB +: 3]   = r.cs;
				end
				timer8_pkg::COUNT_OFS:
					r_nxt.rdata = r.count;
				timer8_pkg::CMP_OFS:
					r_nxt.rdata = r.cmp_buf;
				timer8_pkg::FLAG_OFS:
				begin
					r_nxt.rdata[timer8_pkg::OVF_BIT]  = r.ovf;
					r_nxt.rdata[timer8_pkg::CMPF_BIT] = r.cmpf;
				end
				timer8_pkg::PIN_OFS:
				begin
					r_nxt.rdata[timer8_pkg::STATE_BIT] = r.state;
					r_nxt.rdata[timer8_pkg::DIR_BIT]   = r.dir;
					r_nxt.rdata[timer8_pkg::PORT_BIT]  = r.port;
				end
				default:
					r_nxt.rdata = timer8_pkg::READ_ZERO;
			endcase
		end

		// Override from action field alone; direction bit still gates
		if (r_nxt.act != timer8_pkg::act_none)
			r_nxt.pin_out = r_nxt.state;
		else
			r_nxt.pin_out = r_nxt.port;
		r_nxt.pin_oe = r_nxt.dir;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			r.count   <= timer8_pkg::RESET_BYTE;
			r.cmp_buf <= timer8_pkg::RESET_BYTE;
			r.cmp_act <= timer8_pkg::RESET_BYTE;
			r.wave    <= timer8_pkg::wave_normal;
			r.act     <= timer8_pkg::act_none;
			r.cs      <= timer8_pkg::cs_stop;
			r.ovf     <= 1'b0;
			r.cmpf    <= 1'b0;
			r.state   <= 1'b0;
			r.dir     <= 1'b0;
			r.port    <= 1'b0;
			r.block   <= 1'b0;
			r.rdata   <= timer8_pkg::READ_ZERO;
			r.pin_out <= 1'b0;
			r.pin_oe  <= 1'b0;
		end
		else
		begin
			r <= r_nxt;
		end
	end

	assign rdata    = r.rdata;
	assign ovf_flag = r.ovf;
	assign cmp_flag = r.cmpf;
	assign pin_out  = r.pin_out;
	assign pin_oe   = r.pin_oe;

endmodule : timer8_wavegen

// ==== pin_model.sv ====
// Port pin as the board sees it, with a pull-up
`timescale 1ns/1ns
module pin_model
(
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin_level
);
	// Released pin goes to the pull-up level, never the last value
	assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule : pin_model

// ==== timer8_wavegen_assertions.sv ====
// Port-level checks for the compare and waveform timer
`timescale 1ns/1ns
module timer8_wavegen_assertions
(
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       ovf_ack,
	input wire logic       cmp_ack,
	input wire logic       ovf_flag,
	input wire logic       cmp_flag,
	input wire logic       pin_out,
	input wire logic       pin_oe
);
	logic [2:0] cs_r;
	logic [2:0] stop_r;
	logic       ctl_wr;
	logic       stopped;
	logic       ovf_wc;
	logic       cmp_wc;

	assign ctl_wr  = wr && addr == timer8_pkg::CTRL_OFS;
	assign stopped = cs_r == 3'h0 || cs_r[2:1] == 2'h3;
	assign ovf_wc  = wr && addr == timer8_pkg::FLAG_OFS &&
		wdata[timer8_pkg::OVF_BIT];
	assign cmp_wc  = wr && addr == timer8_pkg::FLAG_OFS &&
		wdata[timer8_pkg::CMPF_BIT];

	// Pending ticks drain within a few cycles of a stop
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cs_r   <= 3'h0;
			stop_r <= 3'h0;
		end
		else
		begin
			cs_r   <= ctl_wr ? wdata[timer8_pkg::CS_LSB +: 3] : cs_r;
			stop_r <= ctl_wr ? 3'h0 : (stopped && stop_r != 3'h7) ?
				stop_r + 3'h1 : stop_r;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence acc(logic s, logic [2:0] a);
		s && addr == a;
	endsequence

	reset_out_a: assert property ($rose(resetn) |-> !ovf_flag &&
		!cmp_flag && !pin_out && !pin_oe) else $error("outputs after reset");
	pin_dir_a: assert property (acc(wr, timer8_pkg::PIN_OFS) |=>
		pin_oe == $past(wdata[timer8_pkg::DIR_BIT]))
		else $error("pin enable wrong");
	ovf_hold_a: assert property (ovf_flag && !ovf_ack && !ovf_wc
		|=> ovf_flag) else $error("overflow flag dropped");
	cmp_hold_a: assert property (cmp_flag && !cmp_ack && !cmp_wc
		|=> cmp_flag) else $error("compare flag dropped");
	stop_quiet_a: assert property (stop_r == 3'h7 |->
		!$rose(ovf_flag) && !$rose(cmp_flag)) else $error("flag while stopped");
	flag_clear_a: assert property (cmp_wc && stop_r == 3'h7
		|=> !cmp_flag) else $error("compare flag not cleared");
	ack_clear_a: assert property (ovf_ack && stop_r == 3'h7
		|=> !ovf_flag) else $error("overflow flag not acked");
	cnt_back_a: assert property (acc(wr && stop_r == 3'h7,
		timer8_pkg::COUNT_OFS) ##2 acc(rd, timer8_pkg::COUNT_OFS) |=>
		rdata == $past(wdata, 3)) else $error("count readback wrong");
	cmp_back_a: assert property (acc(wr, timer8_pkg::CMP_OFS) ##2
		acc(rd, timer8_pkg::CMP_OFS) |=> rdata == $past(wdata, 3))
		else $error("compare readback wrong");
endmodule : timer8_wavegen_assertions

bind timer8_wavegen timer8_wavegen_assertions i_timer8_wavegen_assertions
(
	.core_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .ovf_ack,
	.cmp_ack, .ovf_flag, .cmp_flag, .pin_out, .pin_oe
);

// ==== timer8_compare_waveform_gen_tb.sv ====
// Self-checking testbench for the compare and waveform timer
`timescale 1ns/1ns
module timer8_compare_waveform_gen_tb;
	logic       core_clk = 1'b0;
	logic       resetn   = 1'b0;
	logic [2:0] addr     = 3'h0;
	logic [7:0] wdata    = 8'h00;
	logic       wr       = 1'b0;
	logic       rd       = 1'b0;
	logic       ovf_ack  = 1'b0;
	logic       cmp_ack  = 1'b0;
	logic [7:0] rdata;
	logic       ovf_flag;
	logic       cmp_flag;
	logic       pin_out;
	logic       pin_oe;
	logic       pin_level;
	logic [7:0] d;
	int         n;
	int         num_errors = 0;
	int         tests_run  = 0;

	always #5 core_clk = ~core_clk;

	timer8_wavegen i_timer8_wavegen (.core_clk, .resetn, .addr, .wdata,
		.wr, .rd, .rdata, .ovf_ack, .cmp_ack, .ovf_flag, .cmp_flag,
		.pin_out, .pin_oe);
	pin_model i_pin_model (.pin_out, .pin_oe, .pin_level);

	task automatic chk(input string s, input logic [8:0] e, logic [8:0] g);
		tests_run++;
		if (g !== e)
		begin
			num_errors++;
			$display("FAIL %s expected %0h seen %0h", s, e, g);
		end
	endtask : chk

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge core_clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
		@(posedge core_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg

	// Bounded: a stuck pin ends the run instead of hanging it
	task automatic wait_edge;
		logic p;
		#1 p = pin_level;
		n = 0;
		while (pin_level === p && n < 300)
		begin
			cyc(1);
			n++;
		end
		if (n >= 300)
		begin
			num_errors++;
			$display("FAIL pin edge expected toggle seen none");
			end_of_test();
		end
	endtask : wait_edge

	task automatic t_reset;
		for (int a = 0; a < 8; a++)
		begin
			rd_reg(3'(a), d);
			chk("register at reset", 8'h00, d);
		end
		chk("pin at reset", 1'b0, pin_out);
		$display("reset test done");
	endtask : t_reset

	task automatic t_preset;
		wr_reg(timer8_pkg::PIN_OFS, 8'h00);
		wr_reg(timer8_pkg::CTRL_OFS, 8'h0c);
		cyc(3);
		chk("pin released", 1'b1, pin_level);
		wr_reg(timer8_pkg::PIN_OFS, 8'h02);
		cyc(3);
		chk("pin preset", 1'b0, pin_level);
		wr_reg(timer8_pkg::CTRL_OFS, 8'h8c);
		cyc(3);
		chk("pin forced", 1'b1, pin_level);
		chk("flag on force", 1'b0, cmp_flag);
		wr_reg(timer8_pkg::CTRL_OFS, 8'h80);
		cyc(3);
		chk("pin port value", 1'b0, pin_level);
		wr_reg(timer8_pkg::CTRL_OFS, 8'h08);
		cyc(8);
		chk("state kept", 1'b1, pin_level);
		wr_reg(timer8_pkg::COUNT_OFS, 8'h5a);
		rd_reg(timer8_pkg::COUNT_OFS, d);
		chk("count readback", 8'h5a, d);
		$display("preset test done");
	endtask : t_preset

	task automatic t_ctc;
		wr_reg(timer8_pkg::COUNT_OFS, 8'h00);
		wr_reg(timer8_pkg::CMP_OFS, 8'h03);
		rd_reg(timer8_pkg::CMP_OFS, d);
		chk("compare readback", 8'h03, d);
		wr_reg(timer8_pkg::CTRL_OFS, 8'h16);
		wait_edge();
		wait_edge();
		chk("toggle half period", 9'd4, 9'(n));
		chk("compare flag", 1'b1, cmp_flag);
		wr_reg(timer8_pkg::CTRL_OFS, 8'h06);
		cyc(8);
		wr_reg(timer8_pkg::FLAG_OFS, 8'h02);
		cyc(1);
		chk("compare flag cleared", 1'b0, cmp_flag);
		$display("clear-on-match test done");
	endtask : t_ctc

	task automatic t_normal;
		wr_reg(timer8_pkg::FLAG_OFS, 8'h03);
		wr_reg(timer8_pkg::COUNT_OFS, 8'hfd);
		wr_reg(timer8_pkg::CTRL_OFS, 8'h10);
		n = 0;
		while (ovf_flag !== 1'b1 && n < 20)
		begin
			cyc(1);
			n++;
		end
		chk("overflow set", 1'b1, ovf_flag);
		if (ovf_flag !== 1'b1)
			end_of_test();
		wr_reg(timer8_pkg::CTRL_OFS, 8'h00);
		cyc(8);
		@(posedge core_clk);
		ovf_ack <= 1'b1;
		@(posedge core_clk);
		ovf_ack <= 1'b0;
		cyc(1);
		chk("overflow acked", 1'b0, ovf_flag);
		$display("normal test done");
	endtask : t_normal

	// High time per 256-tick period: polarity, compare, extremes
	task automatic t_fast;
		logic [7:0] ctl [4] = '{8'h1b, 8'h1f, 8'h1b, 8'h1b};
		logic [7:0] cmp [4] = '{8'h40, 8'h40, 8'hff, 8'h00};
		int         hi  [4] = '{65, 191, 256, 1};
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(timer8_pkg::CMP_OFS, cmp[i]);
			wr_reg(timer8_pkg::CTRL_OFS, ctl[i]);
			cyc(600);
			n = 0;
			repeat (256)
			begin
				cyc(1);
				n += int'(pin_level === 1'b1);
			end
			chk("pwm high time", 9'(hi[i]), 9'(n));
		end
		$display("fast pwm test done");
	endtask : t_fast

	// Fast mode toggle spans two periods; overflow still at max
	task automatic t_toggle;
		wr_reg(timer8_pkg::CMP_OFS, 8'h40);
		wr_reg(timer8_pkg::CTRL_OFS, 8'h17);
		cyc(300);
		wait_edge();
		wait_edge();
		chk("fast toggle half period", 9'd256, 9'(n));
		wr_reg(timer8_pkg::FLAG_OFS, 8'h01);
		n = 0;
		while (ovf_flag !== 1'b1 && n < 300)
		begin
			cyc(1);
			n++;
		end
		chk("fast overflow", 1'b1, ovf_flag);
		if (ovf_flag !== 1'b1)
			end_of_test();
		$display("fast toggle test done");
	endtask : t_toggle

	// Count written equal to compare: that match is lost, so wrap first
	task automatic t_block;
		wr_reg(timer8_pkg::CTRL_OFS, 8'h02);
		cyc(2);
		wr_reg(timer8_pkg::CMP_OFS, 8'h10);
		wr_reg(timer8_pkg::FLAG_OFS, 8'h03);
		wr_reg(timer8_pkg::COUNT_OFS, 8'h10);
		wr_reg(timer8_pkg::CTRL_OFS, 8'h12);
		cyc(4);
		chk("match after count write", 1'b0, cmp_flag);
		n = 0;
		while (ovf_flag !== 1'b1 && n < 300)
		begin
			cyc(1);
			n++;
		end
		chk("clear mode overflow", 1'b1, ovf_flag);
		chk("no match before wrap", 1'b0, cmp_flag);
		if (ovf_flag !== 1'b1)
			end_of_test();
		n = 0;
		while (cmp_flag !== 1'b1 && n < 40)
		begin
			cyc(1);
			n++;
		end
		chk("ticks wrap to match", 9'd17, 9'(n));
		@(posedge core_clk);
		cmp_ack <= 1'b1;
		@(posedge core_clk);
		cmp_ack <= 1'b0;
		cyc(1);
		chk("compare flag acked", 1'b0, cmp_flag);
		$display("block and wrap test done");
	endtask : t_block

	initial
	begin
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_preset();
		t_ctc();
		t_normal();
		t_fast();
		t_toggle();
		t_block();
		end_of_test();
	end
endmodule : timer8_compare_waveform_gen_tb
